// *** design/sleep_mask_params.svh ***
// offsets, reset values and field positions of the sleep-state mask registers
// assumes inclusion by bare name from the block
`ifndef SLEEP_MASK_PARAMS_SVH
`define SLEEP_MASK_PARAMS_SVH

`define OFS_SLEEP_CTRL 8'hE4
`define OFS_S1_INPUT_MASK 8'hE5
`define OFS_S1_FAN_MASK 8'hE6
`define OFS_S3_INPUT_MASK 8'hE7
`define OFS_S3_FAN_MASK 8'hE8
`define OFS_S45_INPUT_MASK 8'hEA
`define OFS_STD_INPUT_MASK 8'hEC

`define RST_SLEEP_CTRL 8'h07
`define RST_INPUT_MASK 8'hFF
`define RST_FAN_MASK 4'hF

`define SLEEP_FIELD_MSB 1
`define SLEEP_FIELD_LSB 0
`define SLEEP_RES_MSB 7
`define SLEEP_RES_LSB 2
`define FAN_RES_ZERO 4'h0
`define READ_UNMAPPED 8'h00
`define SLEEP_RES_READ 6'h01
`define RST_SLEEP_FIELD 2'h3
`define FAN_MASK_MSB 3
`define FAN_MASK_LSB 0

`endif

// *** design/sleep_mask_pkg.sv ***
// types shared by the sleep-state mask block and its bench
// assumes sleep_mask_params.svh on the include path
package sleep_mask_pkg;
  typedef enum logic [1:0] {
    SLEEP_S0 = 2'b00,
    SLEEP_S1 = 2'b01,
    SLEEP_S3 = 2'b10,
    SLEEP_S45 = 2'b11
  } sleep_state_t;
endpackage

// *** design/sleep_state_error_masking.sv ***
// sleep-state register bank and error-event masking for inputs and fan pulses
// assumes a register port fed by the serial management slave on sys_clk,
// and error events arriving as same-clock pulses from the status logic
//
// What this block does
// - sleep-state field selects which masks apply
// - in S1 mask input n by bit n
// - in S1 mask fan k by bit k
// - S1 input mask read/write, resets all ones
// - S1 fan mask resets 0Fh, upper bits zero
// - in S3 mask inputs by S3 mask
// - in S4/5 mask inputs by S4/5 mask
// - standard input mask always suppresses errors
`include "sleep_mask_params.svh"

module sleep_state_error_masking #(
  parameter int NUM_INPUTS = 8,
  parameter int NUM_FANS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic force_s45_req,
  input wire logic [NUM_INPUTS-1:0] input_err_evt,
  input wire logic [NUM_FANS-1:0] fan_err_evt,
  output logic [NUM_INPUTS-1:0] input_err_out,
  output logic [NUM_FANS-1:0] fan_err_out,
  output logic [1:0] sleep_state
);

  // the mask registers are byte wide, so other widths cannot be served
  generate
    if (NUM_INPUTS != 8 || NUM_FANS != 4) begin : g_bad_cfg
      $error("mask registers serve exactly 8 inputs and 4 fans");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser for the forcing indication
  // edge, not level: software may rewrite the field while the pin stays high

  logic force_meta_r, force_meta_nxt;
  logic force_sync_r, force_sync_nxt;
  logic force_prev_r, force_prev_nxt;

  always_comb begin
    force_meta_nxt = force_s45_req;
    force_sync_nxt = force_meta_r;
    force_prev_nxt = force_sync_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_meta_r <= 1'b0;
      force_sync_r <= 1'b0;
      force_prev_r <= 1'b0;
    end else begin
      force_meta_r <= force_meta_nxt;
      force_sync_r <= force_sync_nxt;
      force_prev_r <= force_prev_nxt;
    end
  end

  // three edges from pin rise to the field change
  logic force_rise;
  assign force_rise = force_sync_r & ~force_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // register bank

  sleep_mask_pkg::sleep_state_t sleep_r, sleep_nxt;
  logic [7:0] s1_input_mask_r, s1_input_mask_nxt;
  logic [3:0] s1_fan_mask_r, s1_fan_mask_nxt;
  logic [7:0] s3_input_mask_r, s3_input_mask_nxt;
  logic [3:0] s3_fan_mask_r, s3_fan_mask_nxt;
  logic [7:0] s45_input_mask_r, s45_input_mask_nxt;
  logic [7:0] std_input_mask_r, std_input_mask_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] rd_mux;

  // unmapped offsets and reserved bits are simply not stored
  always_comb begin
    sleep_nxt = sleep_r;
    s1_input_mask_nxt = s1_input_mask_r;
    s1_fan_mask_nxt = s1_fan_mask_r;
    s3_input_mask_nxt = s3_input_mask_r;
    s3_fan_mask_nxt = s3_fan_mask_r;
    s45_input_mask_nxt = s45_input_mask_r;
    std_input_mask_nxt = std_input_mask_r;
    if (reg_wr) begin
      unique case (reg_addr)
        `OFS_SLEEP_CTRL:
          sleep_nxt = sleep_mask_pkg::sleep_state_t'(reg_wdata[`SLEEP_FIELD_MSB:`SLEEP_FIELD_LSB]);
        `OFS_S1_INPUT_MASK: s1_input_mask_nxt = reg_wdata;
        `OFS_S1_FAN_MASK: s1_fan_mask_nxt = reg_wdata[`FAN_MASK_MSB:`FAN_MASK_LSB];
        `OFS_S3_INPUT_MASK: s3_input_mask_nxt = reg_wdata;
        `OFS_S3_FAN_MASK: s3_fan_mask_nxt = reg_wdata[`FAN_MASK_MSB:`FAN_MASK_LSB];
        `OFS_S45_INPUT_MASK: s45_input_mask_nxt = reg_wdata;
        `OFS_STD_INPUT_MASK: std_input_mask_nxt = reg_wdata;
        default: ;
      endcase
    end
    // hardware forcing wins over a same-cycle software write
    if (force_rise) begin
      sleep_nxt = sleep_mask_pkg::SLEEP_S45;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read-back

  // read data is latched on the strobe and held for a slow serial shift-out
  always_comb begin
    unique case (reg_addr)
      `OFS_SLEEP_CTRL: rd_mux = {`SLEEP_RES_READ, sleep_r};
      `OFS_S1_INPUT_MASK: rd_mux = s1_input_mask_r;
      `OFS_S1_FAN_MASK: rd_mux = {`FAN_RES_ZERO, s1_fan_mask_r};
      `OFS_S3_INPUT_MASK: rd_mux = s3_input_mask_r;
      `OFS_S3_FAN_MASK: rd_mux = {`FAN_RES_ZERO, s3_fan_mask_r};
      `OFS_S45_INPUT_MASK: rd_mux = s45_input_mask_r;
      `OFS_STD_INPUT_MASK: rd_mux = std_input_mask_r;
      default: rd_mux = `READ_UNMAPPED;
    endcase
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      rdata_nxt = rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // field resets to S4/5, so a cold start masks as in soft-off
      sleep_r <= sleep_mask_pkg::sleep_state_t'(`RST_SLEEP_FIELD);
      s1_input_mask_r <= `RST_INPUT_MASK;
      s1_fan_mask_r <= `RST_FAN_MASK;
      s3_input_mask_r <= `RST_INPUT_MASK;
      s3_fan_mask_r <= `RST_FAN_MASK;
      s45_input_mask_r <= `RST_INPUT_MASK;
      std_input_mask_r <= `RST_INPUT_MASK;
      rdata_r <= `READ_UNMAPPED;
    end else begin
      sleep_r <= sleep_nxt;
      s1_input_mask_r <= s1_input_mask_nxt;
      s1_fan_mask_r <= s1_fan_mask_nxt;
      s3_input_mask_r <= s3_input_mask_nxt;
      s3_fan_mask_r <= s3_fan_mask_nxt;
      s45_input_mask_r <= s45_input_mask_nxt;
      std_input_mask_r <= std_input_mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask selection by sleep state

  logic [7:0] state_input_mask;
  logic [3:0] state_fan_mask;

  // S4/5 has no fan mask register, so fans stay open there
  always_comb begin
    unique case (sleep_r)
      sleep_mask_pkg::SLEEP_S0: begin
        state_input_mask = '0;
        state_fan_mask = '0;
      end
      sleep_mask_pkg::SLEEP_S1: begin
        state_input_mask = s1_input_mask_r;
        state_fan_mask = s1_fan_mask_r;
      end
      sleep_mask_pkg::SLEEP_S3: begin
        state_input_mask = s3_input_mask_r;
        state_fan_mask = s3_fan_mask_r;
      end
      sleep_mask_pkg::SLEEP_S45: begin
        state_input_mask = s45_input_mask_r;
        state_fan_mask = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel event gating

  logic [NUM_INPUTS-1:0] input_out_r, input_out_nxt;
  logic [NUM_FANS-1:0] fan_out_r, fan_out_nxt;
  // standard mask sits outside the state select and applies in every state
  // outputs are registered, so an unmasked event shows one cycle late

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_input
      always_comb begin
        input_out_nxt[gi] = input_err_evt[gi] & ~state_input_mask[gi] & ~std_input_mask_r[gi];
      end
    end
    for (gi = 0; gi < NUM_FANS; gi++) begin : g_fan
      always_comb begin
        fan_out_nxt[gi] = fan_err_evt[gi] & ~state_fan_mask[gi];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_out_r <= '0;
      fan_out_r <= '0;
    end else begin
      input_out_r <= input_out_nxt;
      fan_out_r <= fan_out_nxt;
    end
  end

  assign input_err_out = input_out_r;
  assign fan_err_out = fan_out_r;
  assign sleep_state = sleep_r;
  assign reg_rdata = rdata_r;

endmodule

// *** tb/sleep_mask_props.sv ***
// port assertions for the sleep-state mask block
// assumes the bind below onto sleep_state_error_masking
module sleep_mask_props #(
  parameter int NUM_INPUTS = 8,
  parameter int NUM_FANS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic force_s45_req,
  input wire logic [NUM_INPUTS-1:0] input_err_evt,
  input wire logic [NUM_FANS-1:0] fan_err_evt,
  input wire logic [NUM_INPUTS-1:0] input_err_out,
  input wire logic [NUM_FANS-1:0] fan_err_out,
  input wire logic [1:0] sleep_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_force;
    $rose(force_s45_req);
  endsequence
  a_s0_fans_open: assert property (sleep_state == 2'h0 |=> fan_err_out == $past(fan_err_evt))
    else $error("fan masked in S0");
  a_s45_fans_open: assert property (sleep_state == 2'h3 |=> fan_err_out == $past(fan_err_evt))
    else $error("fan masked in S4/5");
  a_input_no_invent: assert property (1'h1 |=> (input_err_out & ~$past(input_err_evt)) == '0)
    else $error("input error without event");
  a_fan_no_invent: assert property (1'h1 |=> (fan_err_out & ~$past(fan_err_evt)) == '0)
    else $error("fan error without event");
  a_ctrl_read: assert property (s_rd(8'hE4) |=> reg_rdata == {6'h01, $past(sleep_state)})
    else $error("control read wrong");
  a_fan_res_zero: assert property (s_rd(8'hE6) |=> reg_rdata[7:4] == 4'h0)
    else $error("fan mask reserved bits set");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_force_s45: assert property (s_force |-> ##[1:4] sleep_state == 2'h3)
    else $error("force did not reach S4/5");
endmodule

bind sleep_state_error_masking sleep_mask_props #(.NUM_INPUTS(NUM_INPUTS), .NUM_FANS(NUM_FANS)) sleep_mask_props_inst (
  .sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .force_s45_req,
  .input_err_evt, .fan_err_evt, .input_err_out, .fan_err_out, .sleep_state);

// *** tb/sleep_state_error_masking_bench.sv ***
// self-checking bench for the sleep-state mask block
// assumes the design package compiled first
module sleep_state_error_masking_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, force_s45_req = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, input_err_evt = 8'h00, input_err_out;
  logic [3:0] fan_err_evt = 4'h0, fan_err_out;
  logic [1:0] sleep_state;
  int failures = 0, total_checks = 0;
  // state, mask, std mask, input evt, fan evt, input out, fan out
  logic [41:0] rows [6] = '{{2'h0, 8'hFF, 8'h00, 8'hA5, 4'hF, 8'hA5, 4'hF},
    {2'h1, 8'h0F, 8'h00, 8'hFF, 4'hF, 8'hF0, 4'h0}, {2'h1, 8'h3C, 8'h00, 8'h5A, 4'h6, 8'h42, 4'h2},
    {2'h2, 8'h81, 8'h00, 8'hFF, 4'hF, 8'h7E, 4'hE}, {2'h3, 8'h0F, 8'h10, 8'hFF, 4'hF, 8'hE0, 4'hF},
    {2'h0, 8'h00, 8'h55, 8'hFF, 4'h5, 8'hAA, 4'h5}};
  sleep_state_error_masking sleep_state_error_masking_inst (.sys_clk, .rst_n, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .force_s45_req, .input_err_evt, .fan_err_evt, .input_err_out,
    .fan_err_out, .sleep_state);
  always #25 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(posedge sys_clk) #1;
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_rd = 1'h1;
    @(posedge sys_clk) #1;
    reg_rd = 1'h0;
    chk(reg_rdata, e);
  endtask
  task automatic summarize;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'h1;
    chk(sleep_state, sleep_mask_pkg::SLEEP_S45);
    rd(8'hE4, 8'h07);
    rd(8'hE5, 8'hFF);
    rd(8'hE6, 8'h0F);
    rd(8'hE7, 8'hFF);
    rd(8'hE8, 8'h0F);
    rd(8'hEA, 8'hFF);
    rd(8'hEC, 8'hFF);
    foreach (rows[i]) begin
      wr(8'hE4, {6'h00, rows[i][41:40]});
      wr(8'hE5, rows[i][39:32]);
      wr(8'hE6, rows[i][39:32]);
      wr(8'hE7, rows[i][39:32]);
      wr(8'hE8, rows[i][39:32]);
      wr(8'hEA, rows[i][39:32]);
      wr(8'hEC, rows[i][31:24]);
      @(posedge sys_clk) #1;
      input_err_evt = rows[i][23:16];
      fan_err_evt = rows[i][15:12];
      @(posedge sys_clk) #1;
      chk(input_err_out, rows[i][11:4]);
      chk({4'h0, fan_err_out}, {4'h0, rows[i][3:0]});
      input_err_evt = 8'h00;
      fan_err_evt = 4'h0;
    end
    wr(8'hE6, 8'hFF);
    rd(8'hE6, 8'h0F);
    wr(8'hE4, 8'hFC);
    rd(8'hE4, 8'h04);
    wr(8'hE5, 8'h55);
    rd(8'hE5, 8'h55);
    rd(8'hF0, 8'h00);
    force_s45_req = 1'h1;
    repeat (2) @(posedge sys_clk);
    #1 chk(sleep_state, sleep_mask_pkg::SLEEP_S0);
    @(posedge sys_clk) #1;
    chk(sleep_state, sleep_mask_pkg::SLEEP_S45);
    wr(8'hE4, 8'h01);
    rd(8'hE4, 8'h05);
    force_s45_req = 1'h0;
    rst_n = 1'h0;
    @(posedge sys_clk) #1;
    chk(reg_rdata, 8'h00);
    rst_n = 1'h1;
    chk(sleep_state, sleep_mask_pkg::SLEEP_S45);
    rd(8'hE5, 8'hFF);
    rd(8'hE6, 8'h0F);
    summarize();
  end
endmodule
